// [hdl/tsp_pkg.sv]
// Constants for the serial PCM time-division port
package tsp_pkg;
  // Frame geometry
  localparam int FRAME_SLOTS    = 32;
  localparam int BITS_PER_SLOT  = 8;
  localparam int CLKS_PER_BIT   = 2;
  localparam int CNT_W          = 9;
  localparam logic [8:0] CNT_LAST  = 9'h1FF;
  localparam logic [8:0] CNT_RESET = 9'h000;
  // Serial clock rate in kHz and bit rate in kb/s, kept for reference
  localparam int SERIAL_CLK_KHZ = 4096;
  localparam int BIT_RATE_KBPS  = SERIAL_CLK_KHZ / CLKS_PER_BIT;
  // Field positions within the half-bit counter
  localparam int HALF_POS       = 0;
  localparam int BIT_LSB        = 1;
  localparam int BIT_MSB        = 3;
  localparam int SLOT_LSB       = 4;
  localparam int SLOT_MSB       = 8;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  // Frame pulse idle-level detection
  localparam logic [4:0] LOCK_RUN  = 5'h10;
  // Synchroniser bit positions
  localparam int SY_CLK = 0;
  localparam int SY_FRM = 1;
  localparam int SY_RIN = 2;
  localparam int SY_SIN = 3;
  localparam int SY_OE  = 4;
  localparam int SY_W   = 5;
  localparam logic [4:0] SYNC_RESET = 5'h00;
endpackage

// [hdl/tsp_frame_detect.sv]
// Frame pulse convention detector and frame start finder
`timescale 1ns/1ps
module tsp_frame_detect (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic sampleStb,
  input  wire logic frameLevel,
  output logic      frameStart,
  output logic      locked,
  output logic      styleGci
);
  logic       lastLevel_q;
  logic       idleLevel_q;
  logic       locked_q;
  logic [4:0] runCnt_q;
  logic [4:0] runCnt_d;
  wire        sameLevel = (frameLevel == lastLevel_q);
  wire        runDone   = (runCnt_q == tsp_pkg::LOCK_RUN);

  // A long run at one level is the idle level; the pulse is its opposite
  assign runCnt_d   = !sameLevel ? 5'h00 : (runDone ? runCnt_q : runCnt_q + 5'h01);
  assign frameStart = sampleStb && locked_q && (lastLevel_q == idleLevel_q)
                      && (frameLevel != idleLevel_q);
  assign locked     = locked_q;
  assign styleGci   = !idleLevel_q; // Active high pulse idles low

  // Level history sampled once per serial clock fall
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lastLevel_q <= 1'b0;
      idleLevel_q <= 1'b1;
      locked_q    <= 1'b0;
      runCnt_q    <= 5'h00;
    end else if (sampleStb) begin
      lastLevel_q <= frameLevel;
      runCnt_q    <= runCnt_d;
      if (runDone && sameLevel) begin
        idleLevel_q <= frameLevel;
        locked_q    <= 1'b1;
      end
    end
  end

  // Idle level follows a completed run within one sample
  AST_IDLE_LEARN: assert property (@(posedge core_clk) disable iff (rst)
    (sampleStb && runDone && sameLevel) |=> (idleLevel_q == $past(frameLevel) && locked_q))
    else $error("idle level not learned after long run");

  // Frame start only on a transition away from idle
  AST_START_EDGE: assert property (@(posedge core_clk) disable iff (rst)
    frameStart |-> (frameLevel == !idleLevel_q && lastLevel_q == idleLevel_q))
    else $error("frame start without pulse edge");
endmodule

// [hdl/tsp_pcm_port.sv]
// Serial PCM time-division port: two ports, four 32-slot streams
`timescale 1ns/1ps
module tsp_pcm_port (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       serialBitClk,
  input  wire logic       frameSyncIn,
  input  wire logic       outputDriveEnable,
  input  wire logic       ctrlDriveEnableBit,
  input  wire logic       rxInData,
  input  wire logic       sendInData,
  input  wire logic [7:0] sendOutByte,
  input  wire logic [7:0] rxOutByte,
  output logic            sendOutData,
  output logic            sendOutEnN,
  output logic            rxOutData,
  output logic            rxOutEnN,
  output logic [7:0]      rxInByte,
  output logic [7:0]      sendInByte,
  output logic            byteStrobe,
  output logic [4:0]      slotNum,
  output logic            frameLocked,
  output logic            frameStyleGci
);
  logic [tsp_pkg::SY_W-1:0]  syncA_q;
  logic [tsp_pkg::SY_W-1:0]  syncB_q;
  logic                      clkPrev_q;
  logic [tsp_pkg::CNT_W-1:0] cnt_q;
  logic [tsp_pkg::CNT_W-1:0] cnt_d;
  logic                      sendOutEnN_q;
  logic                      rxOutEnN_q;
  logic                      byteStrobe_q;
  logic [4:0]                slotNum_q;
  logic                      locked_q;
  logic                      styleGci_q;
  logic                      txBit_q   [2];
  logic [7:0]                txShift_q [2];
  logic [7:0]                rxShift_q [2];
  logic [7:0]                rxByte_q  [2];
  logic [7:0]                txSrc     [2];
  logic [1:0]                inBit;
  logic                      frameStart;
  logic                      detLocked;
  logic                      detGci;

  // Named views of synchronised pins and of the counter
  wire       clkSync   = syncB_q[tsp_pkg::SY_CLK];
  wire       fallEdge  = clkPrev_q && !clkSync;
  wire       riseEdge  = !clkPrev_q && clkSync;
  wire       driveOn   = syncB_q[tsp_pkg::SY_OE] && ctrlDriveEnableBit;
  wire [2:0] nextBit   = cnt_d[tsp_pkg::BIT_MSB:tsp_pkg::BIT_LSB];
  wire [2:0] curBit    = cnt_q[tsp_pkg::BIT_MSB:tsp_pkg::BIT_LSB];
  wire       bitBegins = fallEdge && !cnt_d[tsp_pkg::HALF_POS];
  wire       loadSlot  = bitBegins && (nextBit == tsp_pkg::BIT_FIRST);
  wire       bitEnds   = riseEdge && cnt_q[tsp_pkg::HALF_POS];
  wire       slotEnds  = bitEnds && (curBit == tsp_pkg::BIT_LAST);

  // Port 1 sends on the send-side output; port 2 on the receive-side output
  assign txSrc[0] = sendOutByte;
  assign txSrc[1] = rxOutByte;
  // Port 1 listens on the receive-side input; port 2 on the send-side input
  assign inBit    = {syncB_q[tsp_pkg::SY_SIN], syncB_q[tsp_pkg::SY_RIN]};
  // Frame pulse restarts the half-bit count; otherwise it wraps every frame
  assign cnt_d    = frameStart ? tsp_pkg::CNT_RESET : cnt_q + 9'h001;

  // Two flip-flops on every pin from outside the core clock domain
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncA_q   <= tsp_pkg::SYNC_RESET;
      syncB_q   <= tsp_pkg::SYNC_RESET;
      clkPrev_q <= 1'b0;
    end else begin
      syncA_q   <= {outputDriveEnable, sendInData, rxInData, frameSyncIn, serialBitClk};
      syncB_q   <= syncA_q;
      clkPrev_q <= clkSync;
    end
  end

  tsp_frame_detect u_detect (
    .core_clk   (core_clk),
    .rst        (rst),
    .sampleStb  (fallEdge),
    .frameLevel (syncB_q[tsp_pkg::SY_FRM]),
    .frameStart (frameStart),
    .locked     (detLocked),
    .styleGci   (detGci)
  );

  // Half-bit counter advances on each serial clock fall
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= tsp_pkg::CNT_RESET;
    end else if (fallEdge) begin
      cnt_q <= cnt_d;
    end
  end

  // Output drive is the AND of pin and control bit, low-true enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sendOutEnN_q <= 1'b1;
      rxOutEnN_q   <= 1'b1;
    end else begin
      sendOutEnN_q <= !driveOn;
      rxOutEnN_q   <= !driveOn;
    end
  end

  // Per-stream shifters: one transmit and one receive lane per port
  for (genvar s = 0; s < 2; s++) begin : g_lane
    // Transmit: load the slot byte at its first bit, MSB first, hold two clocks
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        txShift_q[s] <= 8'h00;
        txBit_q[s]   <= 1'b0;
      end else if (loadSlot) begin
        txShift_q[s] <= txSrc[s];
        txBit_q[s]   <= txSrc[s][7];
      end else if (bitBegins) begin
        txShift_q[s] <= {txShift_q[s][6:0], 1'b0};
        txBit_q[s]   <= txShift_q[s][6];
      end
    end
    // Receive: sample at the closing rise of each bit, late for setup margin
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        rxShift_q[s] <= 8'h00;
        rxByte_q[s]  <= 8'h00;
      end else if (bitEnds) begin
        rxShift_q[s] <= {rxShift_q[s][6:0], inBit[s]};
        if (curBit == tsp_pkg::BIT_LAST) begin
          rxByte_q[s] <= {rxShift_q[s][6:0], inBit[s]};
        end
      end
    end
  end

  // Slot number, byte strobe and detector status to the user side
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      byteStrobe_q <= 1'b0;
      slotNum_q    <= 5'h00;
      locked_q     <= 1'b0;
      styleGci_q   <= 1'b0;
    end else begin
      byteStrobe_q <= slotEnds;
      if (slotEnds) begin
        slotNum_q <= cnt_q[tsp_pkg::SLOT_MSB:tsp_pkg::SLOT_LSB];
      end
      locked_q     <= detLocked;
      styleGci_q   <= detGci;
    end
  end

  // All outputs straight from flip-flops
  assign sendOutData   = txBit_q[0];
  assign rxOutData     = txBit_q[1];
  assign sendOutEnN    = sendOutEnN_q;
  assign rxOutEnN      = rxOutEnN_q;
  assign rxInByte      = rxByte_q[0];
  assign sendInByte    = rxByte_q[1];
  assign byteStrobe    = byteStrobe_q;
  assign slotNum       = slotNum_q;
  assign frameLocked   = locked_q;
  assign frameStyleGci = styleGci_q;

  // Checks
  sequence seqDriveOn;
    driveOn ##1 driveOn;
  endsequence

  sequence seqSlotLoad;
    loadSlot ##1 1'b1;
  endsequence

  AST_DRIVE_ON: assert property (@(posedge core_clk) disable iff (rst)
    seqDriveOn |-> (!sendOutEnN_q && !rxOutEnN_q))
    else $error("outputs not driven with both enables high");

  AST_HIGH_Z: assert property (@(posedge core_clk) disable iff (rst)
    !driveOn |=> (sendOutEnN_q && rxOutEnN_q))
    else $error("output driven while an enable is low");

  AST_SEND_LOAD: assert property (@(posedge core_clk) disable iff (rst)
    seqSlotLoad |-> (sendOutData == $past(sendOutByte[7])))
    else $error("send output missed slot MSB");

  AST_RECV_LOAD: assert property (@(posedge core_clk) disable iff (rst)
    loadSlot |=> (rxOutData == $past(rxOutByte[7])))
    else $error("receive output missed slot MSB");

  AST_IN_STROBE: assert property (@(posedge core_clk) disable iff (rst)
    slotEnds |=> (byteStrobe && rxInByte == $past({rxShift_q[0][6:0], inBit[0]})))
    else $error("receive input byte not delivered");

  // Byte and strobe both registered on the slot end, valid in the same cycle
  AST_SIN_BYTE: assert property (@(posedge core_clk) disable iff (rst)
    byteStrobe |-> (sendInByte == $past({rxShift_q[1][6:0], inBit[1]})))
    else $error("send input byte lost");

  AST_SHIFT_ON_FALL: assert property (@(posedge core_clk) disable iff (rst)
    (sendOutData != $past(sendOutData)) |-> $past(fallEdge))
    else $error("send output changed off a serial clock fall");

  AST_FRAME_ALIGN: assert property (@(posedge core_clk) disable iff (rst)
    (fallEdge && frameStart) |=> (cnt_q == tsp_pkg::CNT_RESET))
    else $error("frame pulse did not realign counter");

  AST_BIT_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    (fallEdge && cnt_d[tsp_pkg::HALF_POS]) |=> $stable(sendOutData))
    else $error("bit changed mid-bit");

  // Strobe is a single core cycle; two serial rises never come back to back
  AST_STROBE_ONE: assert property (@(posedge core_clk) disable iff (rst)
    byteStrobe |=> !byteStrobe)
    else $error("byte strobe longer than one cycle");

  // Slot number names the slot that just closed
  AST_SLOT_NUM: assert property (@(posedge core_clk) disable iff (rst)
    byteStrobe |-> (slotNum == $past(cnt_q[tsp_pkg::SLOT_MSB:tsp_pkg::SLOT_LSB])))
    else $error("slot number does not match closed slot");
endmodule

// [verification/tsp_far_end.sv]
// Far-end framer model: serial clock, frame pulse, input streams, output capture
`timescale 1ns/1ps
module tsp_far_end (
  input  wire logic       pulseHigh,
  input  wire logic [7:0] base,
  input  wire logic       sendWire,
  input  wire logic       rxWire,
  output logic            serialBitClk,
  output logic            frameSyncIn,
  output logic            rxInData,
  output logic            sendInData,
  output logic [7:0]      capSend,
  output logic [7:0]      capRx,
  output logic [4:0]      capSlot,
  output logic            capTog,
  output logic [7:0]      frameBase
);
  logic [8:0] cnt;
  logic [7:0] shS;
  logic [7:0] shR;
  logic [7:0] rxB;
  // Backplane clock runs free, frames follow back to back
  initial begin
    cnt = 9'h1FF;
    capTog = 1'b0;
    serialBitClk = 1'b1;
    frameSyncIn = 1'b1;
    forever begin
      #32 serialBitClk = 1'b0;
      cnt = cnt + 9'h001;
      if (cnt == 9'h000) frameBase = base;
      // New bit at each even fall, MSB first, never changes near the closing rise
      if (!cnt[0]) begin
        rxB = frameBase ^ {cnt[8:4], 3'h0};
        rxInData = rxB[3'h7 - cnt[3:1]];
        sendInData = ~rxB[3'h7 - cnt[3:1]];
      end
      #32 serialBitClk = 1'b1;
      // Pulse active across exactly one fall, the one that opens the frame
      frameSyncIn = (cnt == 9'h1FF) ? pulseHigh : ~pulseHigh;
      // Sample device outputs at the closing rise of each bit
      if (cnt[0]) begin
        shS = {shS[6:0], sendWire};
        shR = {shR[6:0], rxWire};
        if (cnt[3:0] == 4'hF) begin
          capSend = shS;
          capRx = shR;
          capSlot = cnt[8:4];
          capTog = ~capTog;
        end
      end
    end
  end
endmodule

// [verification/tsp_pcm_port_tb_top.sv]
// Testbench: serial PCM port against a far-end framer model
`timescale 1ns/1ps
module tsp_pcm_port_tb_top;
  logic       core_clk, rst, oe, ctrlBit, pulseHigh, live;
  logic [7:0] sendOutByte, rxOutByte, base, rnd, rxInByte, sendInByte, capSend, capRx, fBase;
  logic [4:0] slotNum, capSlot;
  logic       byteStrobe, frameLocked, frameStyleGci, capTog;
  int         fail_count, n_checks, cyc;
  wire        sClk, fSync, rxIn, sendIn, sendOut, sendEnN, rxOut, rxEnN;
  wire        sendWire = sendEnN ? 1'bz : sendOut;
  wire        rxWire = rxEnN ? 1'bz : rxOut;

  tsp_pcm_port uut (.core_clk(core_clk), .rst(rst), .serialBitClk(sClk), .frameSyncIn(fSync),
    .outputDriveEnable(oe), .ctrlDriveEnableBit(ctrlBit), .rxInData(rxIn), .sendInData(sendIn),
    .sendOutByte(sendOutByte), .rxOutByte(rxOutByte), .sendOutData(sendOut),
    .sendOutEnN(sendEnN), .rxOutData(rxOut), .rxOutEnN(rxEnN), .rxInByte(rxInByte),
    .sendInByte(sendInByte), .byteStrobe(byteStrobe), .slotNum(slotNum),
    .frameLocked(frameLocked), .frameStyleGci(frameStyleGci));
  tsp_far_end far (.pulseHigh(pulseHigh), .base(base), .sendWire(sendWire), .rxWire(rxWire),
    .serialBitClk(sClk), .frameSyncIn(fSync), .rxInData(rxIn), .sendInData(sendIn),
    .capSend(capSend), .capRx(capRx), .capSlot(capSlot), .capTog(capTog), .frameBase(fBase));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Expected input byte of a slot: frame base XORed with the slot number in the top bits
  function automatic logic [7:0] expInByte(input logic [7:0] b, input logic [4:0] s);
    return b ^ {s, 3'h0};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Core clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Hang guard, four frames per phase leave ample margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 70000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Input bytes against the far end's pattern; new random output bytes per slot, fixed FF and 00 for slot 0
  always @(posedge core_clk) begin
    if (byteStrobe === 1'b1) begin
      if (live) begin
        chk("slotNum", {3'h0, capSlot}, {3'h0, slotNum});
        chk("rxInByte", expInByte(fBase, capSlot), rxInByte);
        chk("sendInByte", ~expInByte(fBase, capSlot), sendInByte);
      end
      rnd = lfsr(rnd);
      sendOutByte <= (capSlot == 5'h1F) ? 8'hFF : rnd;
      rxOutByte <= (capSlot == 5'h1F) ? 8'h00 : lfsr(rnd);
      base <= rnd ^ 8'h5A;
    end
  end

  // Serial output bytes as seen on the wire by the far end
  always @(capTog) begin
    if (live) begin
      chk("sendOut", sendOutByte, capSend);
      chk("rxOut", rxOutByte, capRx);
    end
  end

  initial begin
    rst = 1'b1;
    oe = 1'b0;
    ctrlBit = 1'b0;
    pulseHigh = 1'b0;
    live = 1'b0;
    rnd = 8'h1C;
    base = 8'h1C;
    sendOutByte = 8'h1C;
    rxOutByte = 8'hE3;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    // Every pin and control bit combination, traffic running meanwhile
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      oe <= i[1];
      ctrlBit <= i[0];
      repeat (4) @(posedge core_clk);
      chk("sendOutEnN", {7'h0, ~(i[1] & i[0])}, {7'h0, sendEnN});
      chk("rxOutEnN", {7'h0, ~(i[1] & i[0])}, {7'h0, rxEnN});
    end
    $display("test done: drive enable");
    // Both pulse conventions, learned afresh after a reset
    for (int p = 0; p < 2; p++) begin
      pulseHigh <= p[0];
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (13200) @(posedge core_clk);
      live = 1'b1;
      repeat (13200) @(posedge core_clk);
      live = 1'b0;
      chk("frameLocked", 8'h01, {7'h0, frameLocked});
      chk("frameStyleGci", {7'h0, p[0]}, {7'h0, frameStyleGci});
      $display("test done: frame pulse style %0d", p);
    end
    report_and_stop();
  end
endmodule
